// ---- src/p7sq_pkg.sv ----
package p7sq_pkg;

   // ************************************************************
   // Bus geometry
   // ************************************************************
   localparam int P7SQ_ADR_W = 32;
   localparam int P7SQ_DAT_W = 32;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [31:0] P7SQ_TRIM_ADDR = 32'h0000_7ccc;
   localparam logic [31:0] P7SQ_LINK_ADDR = 32'h0000_7cd0;

   // ************************************************************
   // Trim register fields and reset value
   // ************************************************************
   localparam int P7SQ_TRIM_LSB = 0;
   localparam int P7SQ_TRIM_MSB = 2;
   localparam int P7SQ_TRIM_RSVD_LSB = 3;
   localparam int P7SQ_TRIM_RSVD_MSB = 7;
   localparam logic [2:0] P7SQ_TRIM_RESET = 3'h0;

   // ************************************************************
   // Trim codes
   // ************************************************************
   localparam logic [2:0] P7SQ_TRIM_NOMINAL = 3'h0;
   localparam logic [2:0] P7SQ_TRIM_DOWN_MIN = 3'h1;
   localparam logic [2:0] P7SQ_TRIM_DOWN_MAX = 3'h5;
   localparam logic [2:0] P7SQ_TRIM_UP_25 = 3'h6;
   localparam logic [2:0] P7SQ_TRIM_UP_12P5 = 3'h7;

   // ************************************************************
   // Threshold in 12.5 mV steps: nominal 100 mV is eight steps
   // ************************************************************
   localparam int P7SQ_STEP_UV = 12500;
   localparam int P7SQ_NOMINAL_UV = 100000;
   localparam logic [3:0] P7SQ_NOMINAL_STEPS = 4'(P7SQ_NOMINAL_UV / P7SQ_STEP_UV);
   localparam logic [3:0] P7SQ_UP_25_STEPS = 4'h2;
   localparam logic [3:0] P7SQ_UP_12P5_STEPS = 4'h1;

   // ************************************************************
   // Link status register fields
   // ************************************************************
   localparam int P7SQ_LS_LSB = 4;
   localparam int P7SQ_LS_MSB = 7;
   localparam int P7SQ_LS_RSVD_BIT = 3;
   localparam int P7SQ_SUB_LSB = 0;
   localparam int P7SQ_SUB_MSB = 2;

   // ************************************************************
   // Link state codes
   // ************************************************************
   localparam logic [3:0] P7SQ_LS_U0 = 4'h0;
   localparam logic [3:0] P7SQ_LS_U1 = 4'h1;
   localparam logic [3:0] P7SQ_LS_U2 = 4'h2;
   localparam logic [3:0] P7SQ_LS_U3 = 4'h3;
   localparam logic [3:0] P7SQ_LS_DISABLED = 4'h4;
   localparam logic [3:0] P7SQ_LS_RX_DETECT = 4'h5;
   localparam logic [3:0] P7SQ_LS_INACTIVE = 4'h6;
   localparam logic [3:0] P7SQ_LS_POLLING = 4'h7;
   localparam logic [3:0] P7SQ_LS_RECOVERY = 4'h8;
   localparam logic [3:0] P7SQ_LS_HOT_RESET = 4'h9;
   localparam logic [3:0] P7SQ_LS_COMPLIANCE = 4'ha;
   localparam logic [3:0] P7SQ_LS_LOOPBACK = 4'hb;
   localparam logic [3:0] P7SQ_LS_RESET = P7SQ_LS_RX_DETECT;
   localparam logic [2:0] P7SQ_SUB_RESET = 3'h0;

endpackage

// ---- src/p7sq_regs.sv ----
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module p7sq_regs
   import p7sq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [P7SQ_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [P7SQ_DAT_W-1:0] wb_dat_i,
   output logic [P7SQ_DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [3:0] link_state_in,
   input wire logic [2:0] link_sub_state_in,
   output logic [2:0] hs_receive_threshold_trim,
   output logic [3:0] squelch_thresh_steps,
   output logic [3:0] link_state_out
);

   // ************************************************************
   // Storage
   // ************************************************************
   logic ack_q;
   logic ack_d;
   logic [P7SQ_DAT_W-1:0] rdata_q;
   logic [P7SQ_DAT_W-1:0] rdata_d;
   logic [2:0] trim_q;
   logic [2:0] trim_d;
   logic [3:0] ls_q;
   logic [3:0] ls_d;
   logic [2:0] sub_q;
   logic [2:0] sub_d;

   // ************************************************************
   // Bus decode
   // ************************************************************
   // Only the word address is compared; byte offsets inside the word are
   // carried by wb_sel_i as usual for a 32-bit classic slave.
   wire req = wb_cyc_i && wb_stb_i && !ack_q;
   wire hit_trim = (wb_adr_i[31:2] == P7SQ_TRIM_ADDR[31:2]);
   wire hit_link = (wb_adr_i[31:2] == P7SQ_LINK_ADDR[31:2]);
   wire hit_none = !hit_trim && !hit_link;
   wire wr_trim = req && wb_we_i && hit_trim && wb_sel_i[0];

   // ************************************************************
   // Read images
   // ************************************************************
   wire [7:0] trim_image = {5'h00, trim_q};
   wire [7:0] link_image = {ls_q, 1'b0, sub_q};

   // ************************************************************
   // Link state capture
   // ************************************************************
   // An out-of-range code from the port logic is never latched; the last
   // legal state stays visible, which is the least surprising thing for
   // software polling a status register.
   wire ls_legal = (link_state_in <= P7SQ_LS_LOOPBACK);

   assign ls_d = ls_legal ? link_state_in : ls_q;
   assign sub_d = ls_legal ? link_sub_state_in : sub_q;
   assign trim_d = wr_trim ? wb_dat_i[P7SQ_TRIM_MSB:P7SQ_TRIM_LSB] : trim_q;
   assign ack_d = req;

   // ************************************************************
   // Read data selection
   // ************************************************************
   // An unmapped address reads as zero instead of raising an error, so that
   // software probing the register space never sees a bus fault.
   wire [7:0] rd_byte_trim = hit_trim ? trim_image : 8'h00;
   wire [7:0] rd_byte_link = hit_link ? link_image : 8'h00;
   wire [7:0] rd_byte = hit_none ? 8'h00 : (rd_byte_trim | rd_byte_link);
   wire [P7SQ_DAT_W-1:0] rd_word = {24'h00_0000, rd_byte};
   // The word is captured on every taken request and then held, so the data
   // stands unchanged for as long as the master may look at it.
   assign rdata_d = req ? rd_word : rdata_q;

   // ************************************************************
   // Flip-flops
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q <= 1'b0;
         rdata_q <= '0;
      end
      else
      begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trim_q <= P7SQ_TRIM_RESET;
      end
      else
      begin
         trim_q <= trim_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ls_q <= P7SQ_LS_RESET;
         sub_q <= P7SQ_SUB_RESET;
      end
      else
      begin
         ls_q <= ls_d;
         sub_q <= sub_d;
      end
   end

   // ************************************************************
   // Threshold decode
   // ************************************************************
   p7sq_thresh u_thresh (
      .mclk(mclk),
      .rst_n(rst_n),
      .trim(trim_q),
      .thresh_steps_q(squelch_thresh_steps)
   );

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign hs_receive_threshold_trim = trim_q;
   assign link_state_out = ls_q;

endmodule
`default_nettype wire

// ---- src/p7sq_thresh.sv ----
`timescale 1ns/1ps
`default_nettype none

module p7sq_thresh
   import p7sq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [2:0] trim,
   output logic [3:0] thresh_steps_q
);

   logic [3:0] thresh_steps_d;
   wire trim_is_down = (trim >= P7SQ_TRIM_DOWN_MIN) && (trim <= P7SQ_TRIM_DOWN_MAX);
   wire [3:0] down_steps = P7SQ_NOMINAL_STEPS - {1'b0, trim};

   // ************************************************************
   // Trim code to threshold, in 12.5 mV steps
   // ************************************************************
   always_comb
   begin
      thresh_steps_d = P7SQ_NOMINAL_STEPS;
      if (trim_is_down)
      begin
         thresh_steps_d = down_steps;
      end
      else if (trim == P7SQ_TRIM_UP_25)
      begin
         thresh_steps_d = P7SQ_NOMINAL_STEPS + P7SQ_UP_25_STEPS;
      end
      else if (trim == P7SQ_TRIM_UP_12P5)
      begin
         thresh_steps_d = P7SQ_NOMINAL_STEPS + P7SQ_UP_12P5_STEPS;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         thresh_steps_q <= P7SQ_NOMINAL_STEPS;
      end
      else
      begin
         thresh_steps_q <= thresh_steps_d;
      end
   end

endmodule
`default_nettype wire

// ---- tb/p7sq_regs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module p7sq_regs_props
   import p7sq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [P7SQ_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [P7SQ_DAT_W-1:0] wb_dat_i,
   input wire logic [P7SQ_DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [3:0] link_state_in,
   input wire logic [2:0] hs_receive_threshold_trim,
   input wire logic [3:0] squelch_thresh_steps,
   input wire logic [3:0] link_state_out
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   wire [2:0] tr = hs_receive_threshold_trim;
   wire ta = wb_adr_i[31:2] == P7SQ_TRIM_ADDR[31:2];
   wire la = wb_adr_i[31:2] == P7SQ_LINK_ADDR[31:2];
   wire tw = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && ta;
   wire [3:0] mp = tr == 3'h6 ? 4'ha : tr == 3'h7 ? 4'h9 : 4'h8 - 4'(tr);
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("long ack");
   chk_trim_write: assert property (tw |=> tr == $past(wb_dat_i[2:0]))
      else $error("trim not written");
   chk_trim_hold: assert property (!tw |=> $stable(tr))
      else $error("trim moved");
   chk_rsvd_zero: assert property (wb_ack_o && !wb_we_i && ta |-> wb_dat_o[31:3] == '0)
      else $error("reserved set");
   chk_thresh_map: assert property (1'b1 |=> squelch_thresh_steps == $past(mp))
      else $error("bad threshold");
   chk_link_follow: assert property (link_state_in <= 4'hb
      |=> link_state_out == $past(link_state_in)) else $error("state lost");
   chk_link_hold: assert property (link_state_in > 4'hb |=> $stable(link_state_out))
      else $error("bad state latched");
   chk_link_rsvd: assert property (wb_ack_o && !wb_we_i && la
      |-> !wb_dat_o[3] && wb_dat_o[31:8] == '0) else $error("link reserved set");
   chk_link_legal: assert property (link_state_out <= 4'hb)
      else $error("illegal state shown");
endmodule
bind p7sq_regs p7sq_regs_props u_p7sq_regs_props (
   .mclk(mclk),
   .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .link_state_in(link_state_in),
   .hs_receive_threshold_trim(hs_receive_threshold_trim),
   .squelch_thresh_steps(squelch_thresh_steps),
   .link_state_out(link_state_out)
);
`default_nettype wire

// ---- tb/p7sq_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module p7sq_regs_tb_top
   import p7sq_pkg::*;
;
   logic mclk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, wb_ack_o;
   logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd, d;
   logic [3:0] wb_sel_i = '0, link_state_in = 4'h5, squelch_thresh_steps, link_state_out;
   logic [2:0] link_sub_state_in = '0, hs_receive_threshold_trim, tr = '0;
   logic [6:0] e = 7'h05;
   int num_errors = 0, n_compared = 0, i, t;
   p7sq_regs u_p7sq_regs (
      .mclk(mclk),
      .rst_n(rst_n),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .link_state_in(link_state_in),
      .link_sub_state_in(link_sub_state_in),
      .hs_receive_threshold_trim(hs_receive_threshold_trim),
      .squelch_thresh_steps(squelch_thresh_steps),
      .link_state_out(link_state_out)
   );
   always #2.5 mclk = ~mclk;
   task automatic conclude;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] x, logic [31:0] s);
      n_compared++;
      num_errors += int'(s !== x);
      if (s !== x)
         $display("ERROR %s exp %h got %h", n, x, s);
   endtask
   task automatic wb(logic w, logic [31:0] a, logic [3:0] s, logic [31:0] x);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= x;
      i = 0;
      do
         @(posedge mclk);
      while (wb_ack_o !== 1'b1 && ++i < 20);
      chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
      if (wb_ack_o !== 1'b1)
         conclude();
      else
      begin
         rd = wb_dat_o;
         {wb_cyc_i, wb_stb_i} <= 2'b00;
         @(posedge mclk);
      end
   endtask
   function automatic logic [31:0] xs(logic [2:0] c);
      return c == 3'h6 ? 32'ha : c == 3'h7 ? 32'h9 : 32'h8 - c;
   endfunction
   initial
   begin
      void'($urandom(24));
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      wb(1'b0, P7SQ_LINK_ADDR, 4'hf, '0);
      chk("link", 32'h50, rd);
      // The last two passes write without lane 0, so the trim must not move.
      for (t = 0; t < 10; t++)
      begin
         wb(1'b0, P7SQ_TRIM_ADDR, 4'h1, '0);
         chk("trim", {29'h0, tr}, rd);
         chk("steps", xs(tr), {28'h0, squelch_thresh_steps});
         chk("trim_out", {29'h0, tr}, {29'h0, hs_receive_threshold_trim});
         d = $urandom;
         wb(1'b1, P7SQ_TRIM_ADDR, t < 8 ? 4'h1 : 4'h0, {d[31:3], t[2:0]});
         if (t < 8)
            tr = t[2:0];
      end
      // A reset in mid-run must bring the trim back to nominal.
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      tr = P7SQ_TRIM_RESET;
      @(posedge mclk);
      chk("trim_out", {29'h0, tr}, {29'h0, hs_receive_threshold_trim});
      chk("steps", xs(tr), {28'h0, squelch_thresh_steps});
      wb(1'b0, P7SQ_TRIM_ADDR, 4'h1, '0);
      chk("trim", {29'h0, tr}, rd);
      wb(1'b1, P7SQ_LINK_ADDR, 4'hf, $urandom);
      wb(1'b0, 32'h0000_7cd4, 4'hf, '0);
      chk("unmapped", '0, rd);
      for (t = 0; t < 40; t++)
      begin
         d = t < 16 ? t : $urandom;
         link_state_in <= d[3:0];
         link_sub_state_in <= d[6:4];
         if (d[3:0] <= 4'hb)
            e = d[6:0];
         @(posedge mclk);
         wb(1'b0, P7SQ_LINK_ADDR, 4'hf, '0);
         chk("link", {24'h0, e[3:0], 1'b0, e[6:4]}, rd);
         chk("state", {28'h0, e[3:0]}, link_state_out);
      end
      conclude();
   end
endmodule
`default_nettype wire
